// ### src/mcu_control.sv
// MCU control register: debug port, brown-out sleep, pull-ups, vectors.
// Assumes requests, fuses and core strobes are synchronous to clk_in and
// that fuse inputs are high when the fuse or lock bit is programmed.

`timescale 1ns/1ps

module mcu_control
    import mcu_control_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire reg_req_t req_in,
    input wire fuse_t fuse_in,
    input wire logic exec_boot_in,
    input wire logic instr_done_in,
    input wire logic sleep_in,
    input wire logic sleep_exit_in,
    input wire logic [4:0] vector_num_in,
    input wire logic [7:0] pin_direction_bit_in,
    input wire logic [7:0] pin_output_bit_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic debug_port_enable_out,
    output logic brownout_off_out,
    output logic irq_block_out,
    output logic [15:0] vector_addr_out,
    output logic [15:0] reset_addr_out,
    output logic [7:0] pullup_en_out
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic [7:0] wd;

    // I/O space only covers offsets below the extended area
    assign hit = req_in.io
        ? (req_in.addr == IO_OFFS) // RL13
        : (req_in.addr == DATA_OFFS) && (DATA_OFFS < EXT_IO_START); // RL13
    assign wr_hit = hit && req_in.wr;
    assign rd_hit = hit && req_in.rd;
    assign wd = req_in.wdata;

    // ------------------------------------------------------------
    // Debug port disable
    // ------------------------------------------------------------
    logic debug_port_disable;
    logic dbg_pend;
    logic [2:0] dbg_timer;

    // A write outside the window arms its value instead of landing
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            debug_port_disable <= 1'b0;
            dbg_pend <= 1'b0;
            dbg_timer <= 3'h0;
        end else if (ce_in) begin
            if (wr_hit) begin
                if (dbg_timer != 3'h0 && wd[BIT_DBG_OFF] == dbg_pend) begin
                    debug_port_disable <= dbg_pend; // RL2
                    dbg_timer <= 3'h0;
                end else begin
                    dbg_pend <= wd[BIT_DBG_OFF];
                    dbg_timer <= WIN_CYC; // RL2
                end
            end else if (dbg_timer != 3'h0) begin
                dbg_timer <= dbg_timer - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            debug_port_enable_out <= 1'b0;
        end else if (ce_in) begin
            debug_port_enable_out <=
                !debug_port_disable && fuse_in.debug_port_fuse; // RL1
        end
    end

    // ------------------------------------------------------------
    // Brown-out sleep-off sequence
    // ------------------------------------------------------------
    logic brownout_sleep_unlock;
    logic [2:0] unlock_timer;
    logic [2:0] sleep_off_cnt;
    logic brownout_sleep_off;
    logic sleep_off_live;

    // Counter runs the delay, then the hold; only the hold lets sleep act
    assign brownout_sleep_off = (sleep_off_cnt != 3'h0);
    assign sleep_off_live = brownout_sleep_off
        && (sleep_off_cnt <= SLEEP_OFF_HOLD);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            brownout_sleep_unlock <= 1'b0;
            unlock_timer <= 3'h0;
        end else if (ce_in) begin
            if (wr_hit) begin
                if (wd[BIT_SLEEP_OFF] && wd[BIT_SLEEP_KEY]) begin
                    brownout_sleep_unlock <= 1'b1; // RL3
                    unlock_timer <= WIN_CYC;
                end else begin
                    brownout_sleep_unlock <= 1'b0;
                    unlock_timer <= 3'h0;
                end
            end else if (unlock_timer == 3'h1) begin
                brownout_sleep_unlock <= 1'b0; // RL3
                unlock_timer <= 3'h0;
            end else if (unlock_timer != 3'h0) begin
                unlock_timer <= unlock_timer - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sleep_off_cnt <= 3'h0;
        end else if (ce_in) begin
            if (wr_hit && brownout_sleep_unlock && wd[BIT_SLEEP_OFF]
                    && !wd[BIT_SLEEP_KEY]) begin
                sleep_off_cnt <= SLEEP_OFF_TOTAL; // RL3
            end else if (sleep_off_cnt != 3'h0) begin
                sleep_off_cnt <= sleep_off_cnt - 3'h1; // RL4
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            brownout_off_out <= 1'b0;
        end else if (ce_in) begin
            if (sleep_in && sleep_off_live) begin
                brownout_off_out <= 1'b1; // RL5
            end else if (sleep_exit_in) begin
                brownout_off_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pull-up disable and per-pin pull-ups
    // ------------------------------------------------------------
    logic pullup_global_off;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pullup_global_off <= 1'b0;
        end else if (ce_in && wr_hit) begin
            pullup_global_off <= wd[BIT_PULL_OFF];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pull
            always_ff @(posedge clk_in) begin
                if (!rstn_in) begin
                    pullup_en_out[gi] <= 1'b0;
                end else if (ce_in) begin
                    pullup_en_out[gi] <= !pin_direction_bit_in[gi]
                        && pin_output_bit_in[gi]
                        && !pullup_global_off; // RL6
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Vector table select sequence
    // ------------------------------------------------------------
    iv_state_t iv_state;
    logic [2:0] iv_timer;
    logic vector_table_select;
    logic vector_change_unlock;
    logic lock_block;
    logic unlock_now;

    assign vector_change_unlock = (iv_state == IV_OPEN);

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            iv_state <= IV_IDLE;
            iv_timer <= 3'h0;
            vector_table_select <= 1'b0;
        end else if (ce_in) begin
            case (iv_state)
                IV_IDLE: begin
                    if (wr_hit && wd[BIT_VEC_KEY]) begin
                        iv_state <= IV_OPEN;
                        iv_timer <= WIN_CYC;
                    end
                end
                IV_OPEN: begin
                    if (wr_hit && wd[BIT_VEC_KEY]) begin
                        iv_timer <= WIN_CYC;
                    end else if (wr_hit) begin
                        vector_table_select <= wd[BIT_VEC_SEL]; // RL8
                        iv_state <= IV_HOLD; // RL11
                        iv_timer <= 3'h0;
                    end else if (iv_timer == 3'h1) begin
                        iv_state <= IV_IDLE; // RL11
                        iv_timer <= 3'h0;
                    end else begin
                        iv_timer <= iv_timer - 3'h1;
                    end
                end
                IV_HOLD: begin
                    if (instr_done_in) begin
                        iv_state <= IV_IDLE; // RL9
                    end
                end
                default: begin
                    iv_state <= IV_IDLE;
                    iv_timer <= 3'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt blocking, separate from the core flag register
    // ------------------------------------------------------------
    assign lock_block =
        (vector_table_select && fuse_in.app_side_boot_lock
            && !exec_boot_in) // RL12
        || (!vector_table_select && fuse_in.boot_side_boot_lock
            && exec_boot_in); // RL12

    // Unlock write blocks in its own cycle, before the state moves
    assign unlock_now = ce_in && wr_hit && (iv_state == IV_IDLE)
        && wd[BIT_VEC_KEY]; // RL9

    // Separate gate; the core's own enable flag is never written
    assign irq_block_out = (iv_state != IV_IDLE) // RL9 RL10
        || unlock_now // RL9
        || lock_block;

    // ------------------------------------------------------------
    // Vector and reset addresses
    // ------------------------------------------------------------
    logic [15:0] next_vector_addr;
    logic [15:0] next_reset_addr;
    logic [15:0] boot_base;
    logic [15:0] vec_offs;

    assign boot_base = BOOT_START[fuse_in.boot_size_fuses];
    assign vec_offs = {10'h000, vector_num_in, 1'b0};

    always_comb begin
        next_reset_addr = RESET_APP;
        if (fuse_in.boot_reset_fuse) begin
            next_reset_addr = boot_base; // RL17
        end
        next_vector_addr = vec_offs; // RL7
        if (vector_table_select) begin
            next_vector_addr = boot_base + vec_offs; // RL7 RL16
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            vector_addr_out <= RESET_APP;
            reset_addr_out <= RESET_APP;
        end else if (ce_in) begin
            vector_addr_out <= next_vector_addr;
            reset_addr_out <= next_reset_addr;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] rd_word;

    always_comb begin
        rd_word = MCU_RESET; // RL18
        rd_word[BIT_DBG_OFF] = debug_port_disable;
        rd_word[BIT_SLEEP_OFF] = brownout_sleep_off;
        rd_word[BIT_SLEEP_KEY] = brownout_sleep_unlock;
        rd_word[BIT_PULL_OFF] = pullup_global_off;
        rd_word[BIT_VEC_SEL] = vector_table_select;
        rd_word[BIT_VEC_KEY] = vector_change_unlock;
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rd_data_out <= MCU_RESET;
            rd_valid_out <= 1'b0;
        end else if (ce_in) begin
            rd_valid_out <= rd_hit;
            if (rd_hit) begin
                rd_data_out <= rd_word;
            end
        end
    end

endmodule : mcu_control

// ### src/mcu_control_pkg.sv
// Constants and types of the MCU control register with timed writes.
// Assumes one system clock; the core presents each register access as a
// one-cycle request in the same clock domain.
//
// Behaviour
// RL1: Debug port enabled only when disable bit is zero and fuse programmed.
// RL2: Debug disable changes only when one value is written twice in four.
// RL3: Sleep-off sets only by both bits one, then sleep-off alone within four.
// RL4: Sleep-off active three cycles after set, cleared three cycles later.
// RL5: Brown-out detector off only if sleep executes while sleep-off active.
// RL6: Global pull-up off forces every port pull-up off.
// RL7: Vector select zero puts vectors at flash start, one at boot section.
// RL8: Vector select changes only by a select write within four of unlock.
// RL9: Interrupts masked from unlock until next instruction, or four cycles.
// RL10: Automatic masking leaves the processor global interrupt flag untouched.
// RL11: Vector unlock clears four cycles after setting or at the select write.
// RL12: Boot lock bits block interrupts from the section not holding vectors.
// RL13: Register answers at data offset 0x55 and I/O offset 0x35.
// RL14: Extended I/O space from 0x60 only reachable by data-space accesses.
// RL15: Software leaves the debug port disable alone while debugging.
// RL16: Relocated vector address is table address plus boot section start.
// RL17: Reset from zero or boot reset address; vectors start 0x0002 above it.
// RL18: Bits 3 and 2 read zero; all implemented bits reset to zero.

package mcu_control_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] DATA_OFFS = 16'h0055;
    localparam logic [15:0] IO_SHIFT = 16'h0020;
    localparam logic [15:0] IO_OFFS = DATA_OFFS - IO_SHIFT;
    localparam logic [15:0] EXT_IO_START = 16'h0060;
    localparam logic [7:0] MCU_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_DBG_OFF = 7;
    localparam int BIT_SLEEP_OFF = 6;
    localparam int BIT_SLEEP_KEY = 5;
    localparam int BIT_PULL_OFF = 4;
    localparam int BIT_VEC_SEL = 1;
    localparam int BIT_VEC_KEY = 0;

    // ------------------------------------------------------------
    // Timing in clock cycles
    // ------------------------------------------------------------
    localparam logic [2:0] WIN_CYC = 3'h4;
    localparam logic [2:0] SLEEP_OFF_DELAY = 3'h3;
    localparam logic [2:0] SLEEP_OFF_HOLD = 3'h3;
    localparam logic [2:0] SLEEP_OFF_TOTAL = SLEEP_OFF_DELAY + SLEEP_OFF_HOLD;

    // ------------------------------------------------------------
    // Flash word addresses
    // ------------------------------------------------------------
    localparam logic [15:0] RESET_APP = 16'h0000;
    localparam logic [15:0] VEC_FIRST = 16'h0002;
    localparam logic [15:0] BOOT_START [4] = '{
        16'h1f00, 16'h1e00, 16'h1c00, 16'h1800
    };

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic io;
        logic [15:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic debug_port_fuse;
        logic [1:0] boot_size_fuses;
        logic boot_reset_fuse;
        logic app_side_boot_lock;
        logic boot_side_boot_lock;
    } fuse_t;

    typedef enum logic [1:0] {
        IV_IDLE,
        IV_OPEN,
        IV_HOLD
    } iv_state_t;

endpackage : mcu_control_pkg

// ### verif/mcu_control_assertions.sv
// Port checker for the MCU control register.
// Assumes the bench keeps the boot lock fuses low around vector moves.
`timescale 1ns/1ps

module mcu_control_assertions
    import mcu_control_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire reg_req_t req_in,
    input wire fuse_t fuse_in,
    input wire logic instr_done_in,
    input wire logic sleep_in,
    input wire logic sleep_exit_in,
    input wire logic [7:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic debug_port_enable_out,
    input wire logic brownout_off_out,
    input wire logic irq_block_out
);
    // ------------------------------------------------------------
    // Helpers and sequences
    // ------------------------------------------------------------
    logic hit;
    logic no_lock;
    assign hit = ce_in && req_in.addr == (req_in.io ? IO_OFFS : DATA_OFFS);
    assign no_lock = !fuse_in.app_side_boot_lock
        && !fuse_in.boot_side_boot_lock;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    sequence s_unlock;
        hit && req_in.wr && req_in.wdata[0] && no_lock;
    endsequence
    sequence s_select;
        hit && req_in.wr && !req_in.wdata[0];
    endsequence

    a_read_answer: assert property (hit && req_in.rd |=> rd_valid_out)
        else $error("read hit got no answer");
    a_no_stray_valid: assert property (
        ce_in && !(hit && req_in.rd) |=> !rd_valid_out)
        else $error("answer without read hit");
    a_debug_port_gate: assert property (rd_valid_out |->
        debug_port_enable_out == (!rd_data_out[7]
        && $past(fuse_in.debug_port_fuse)))
        else $error("debug port enable wrong");
    a_unused_bits_zero: assert property (
        rd_valid_out |-> rd_data_out[3:2] == 2'h0)
        else $error("unused bits not zero");
    a_block_on_unlock: assert property (s_unlock |-> irq_block_out)
        else $error("no block at unlock");
    a_unlock_times_out: assert property (s_unlock ##1
        (ce_in && !(hit && req_in.wr) && no_lock)[*4] |=> !irq_block_out)
        else $error("block outlived window");
    a_select_holds_block: assert property (s_unlock ##2 s_select
        ##1 (ce_in && !instr_done_in && !(hit && req_in.wr))[*5]
        |-> irq_block_out)
        else $error("block dropped before instruction");
    a_exit_clears_off: assert property (
        ce_in && sleep_exit_in && !sleep_in |=> !brownout_off_out)
        else $error("brownout off after exit");
    a_off_needs_sleep: assert property (
        $rose(brownout_off_out) |-> $past(sleep_in && ce_in))
        else $error("brownout off without sleep");
endmodule : mcu_control_assertions

bind mcu_control mcu_control_assertions chk_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .req_in(req_in),
    .fuse_in(fuse_in), .instr_done_in(instr_done_in), .sleep_in(sleep_in),
    .sleep_exit_in(sleep_exit_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .irq_block_out(irq_block_out),
    .debug_port_enable_out(debug_port_enable_out),
    .brownout_off_out(brownout_off_out));

// ### verif/mcu_control_tb.sv
// Self-checking bench for the MCU control register.
// Assumes inputs change at the falling edge; reset held for 8 cycles.
`timescale 1ns/1ps

module mcu_control_tb;
    import mcu_control_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic ce_in = 1'b1;
    reg_req_t req_in = '0;
    fuse_t fuse_in = '0;
    logic exec_boot_in = 1'b0;
    logic instr_done_in = 1'b0;
    logic sleep_in = 1'b0;
    logic sleep_exit_in = 1'b0;
    logic [4:0] vector_num_in = 5'h00;
    logic [7:0] pin_direction_bit_in = 8'h00;
    logic [7:0] pin_output_bit_in = 8'h00;
    logic [7:0] rd_data_out, pullup_en_out;
    logic rd_valid_out, debug_port_enable_out, brownout_off_out;
    logic irq_block_out;
    logic [15:0] vector_addr_out, reset_addr_out;
    int fails = 0;
    int n_compared = 0;

    always #50 clk_in = ~clk_in;

    mcu_control dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
        .req_in(req_in), .fuse_in(fuse_in), .exec_boot_in(exec_boot_in),
        .instr_done_in(instr_done_in), .sleep_in(sleep_in),
        .sleep_exit_in(sleep_exit_in), .vector_num_in(vector_num_in),
        .pin_direction_bit_in(pin_direction_bit_in),
        .pin_output_bit_in(pin_output_bit_in), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out), .irq_block_out(irq_block_out),
        .debug_port_enable_out(debug_port_enable_out),
        .brownout_off_out(brownout_off_out),
        .vector_addr_out(vector_addr_out), .reset_addr_out(reset_addr_out),
        .pullup_en_out(pullup_en_out));

    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    function automatic logic [15:0] exp_vec(input logic [4:0] n,
        input logic sel, input logic [1:0] sz);
        return {10'h000, n, 1'h0} + (sel ? BOOT_START[sz] : 16'h0000);
    endfunction : exp_vec

    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    task automatic idle(input int n);
        repeat (n) @(negedge clk_in);
    endtask : idle

    // Write d, or read and expect d; address space picked at random
    task automatic acc(input logic rd, input logic [7:0] d);
        logic io;
        io = 1'($urandom);
        @(negedge clk_in);
        req_in = '{rd, !rd, io, io ? IO_OFFS : DATA_OFFS, d};
        @(negedge clk_in);
        req_in = '0;
        if (rd) begin
            chk("rd_valid", 16'h0001, {15'h0000, rd_valid_out});
            chk("rd_data", {8'h00, d}, {8'h00, rd_data_out});
        end
    endtask : acc

    task automatic pulse(ref logic s);
        @(negedge clk_in);
        s = 1'b1;
        @(negedge clk_in);
        s = 1'b0;
    endtask : pulse

    task automatic flag(input string what, input logic exp, input logic got);
        chk(what, {15'h0000, exp}, {15'h0000, got});
    endtask : flag

    task automatic vecs(input logic sel);
        for (int i = 0; i < 8; i++) begin
            vector_num_in = 5'($urandom);
            fuse_in.boot_size_fuses = 2'($urandom);
            fuse_in.boot_reset_fuse = 1'($urandom);
            idle(2);
            chk("vector", exp_vec(vector_num_in, sel,
                fuse_in.boot_size_fuses), vector_addr_out);
            chk("reset_addr", fuse_in.boot_reset_fuse ?
                BOOT_START[fuse_in.boot_size_fuses] : RESET_APP,
                reset_addr_out);
        end
    endtask : vecs

    task automatic lockchk(input logic app, input logic boot,
        input logic ex, input logic exp);
        fuse_in.app_side_boot_lock = app;
        fuse_in.boot_side_boot_lock = boot;
        exec_boot_in = ex;
        idle(1);
        flag("lock_block", exp, irq_block_out);
    endtask : lockchk

    initial begin
        logic [7:0] w;
        w = 8'($urandom(38));
        fuse_in.debug_port_fuse = 1'b1;
        idle(8);
        rstn_in = 1'b1;
        acc(1, 8'h00);
        @(negedge clk_in);
        req_in = '{1'b1, 1'b0, 1'b1, DATA_OFFS, 8'h00};
        @(negedge clk_in);
        req_in = '0;
        flag("stray_valid", 1'b0, rd_valid_out);
        ce_in = 1'b0;
        acc(0, 8'h10);
        ce_in = 1'b1;
        acc(1, 8'h00);
        vecs(1'b0);
        for (int i = 0; i < 12; i++) begin
            w = 8'($urandom) & 8'h1e;
            pin_direction_bit_in = 8'($urandom);
            pin_output_bit_in = 8'($urandom);
            acc(0, w);
            acc(1, {3'h0, w[4], 4'h0});
            chk("pullup", {8'h00, w[4] ? 8'h00 : ~pin_direction_bit_in
                & pin_output_bit_in}, {8'h00, pullup_en_out});
        end
        acc(0, 8'h00);
        acc(0, 8'h80);
        idle(4);
        acc(1, 8'h00);
        acc(0, 8'h80);
        acc(0, 8'h80);
        acc(1, 8'h80);
        flag("debug_en", 1'b0, debug_port_enable_out);
        acc(0, 8'h00);
        acc(0, 8'h00);
        acc(1, 8'h00);
        flag("debug_en", 1'b1, debug_port_enable_out);
        fuse_in.debug_port_fuse = 1'b0;
        idle(2);
        flag("debug_en", 1'b0, debug_port_enable_out);
        fuse_in.debug_port_fuse = 1'b1;
        acc(0, 8'h40);
        pulse(sleep_in);
        flag("bod_off", 1'b0, brownout_off_out);
        acc(0, 8'h60);
        acc(0, 8'h40);
        pulse(sleep_in);
        flag("bod_off", 1'b0, brownout_off_out);
        idle(6);
        acc(0, 8'h60);
        acc(0, 8'h40);
        acc(1, 8'h40);
        idle(2);
        pulse(sleep_in);
        flag("bod_off", 1'b1, brownout_off_out);
        idle(1);
        acc(1, 8'h00);
        pulse(sleep_exit_in);
        flag("bod_off", 1'b0, brownout_off_out);
        acc(0, 8'h01);
        acc(0, 8'h02);
        acc(1, 8'h02);
        idle(5);
        flag("irq_block", 1'b1, irq_block_out);
        pulse(instr_done_in);
        flag("irq_block", 1'b0, irq_block_out);
        acc(0, 8'h01);
        idle(5);
        acc(0, 8'h00);
        acc(1, 8'h02);
        flag("irq_block", 1'b0, irq_block_out);
        vecs(1'b1);
        lockchk(1'b1, 1'b0, 1'b0, 1'b1);
        lockchk(1'b1, 1'b0, 1'b1, 1'b0);
        lockchk(1'b0, 1'b0, 1'b0, 1'b0);
        acc(0, 8'h01);
        acc(0, 8'h00);
        pulse(instr_done_in);
        lockchk(1'b0, 1'b1, 1'b1, 1'b1);
        lockchk(1'b0, 1'b1, 1'b0, 1'b0);
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clk_in);
        fails++;
        close_out();
    end
endmodule : mcu_control_tb
